/* write_core_model.sv */
// core-side model taking write requests and payload beats
`default_nettype none
module write_core_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // pacing
  input  wire logic slow,
  // request and payload ports
  input  wire logic write_request_valid,
  output logic      write_request_accept,
  input  wire logic payload_beat_valid,
  output logic      payload_beat_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int pending;
  int beats;
  int next_pending;
  int seed = 11;
  initial begin
    write_request_accept = 1'b0;
    payload_beat_ready = 1'b0;
  end
  // payloads may finish before their request, so pending may dip below zero
  always @(posedge core_clk) begin
    next_pending = pending + int'(write_request_valid && write_request_accept);
    if (payload_beat_valid && payload_beat_ready) begin
      next_pending -= int'(beats == 127);
      beats = (beats == 127) ? 0 : beats + 1;
    end
    if (srst) begin
      next_pending = 0;
      beats = 0;
    end
    pending = next_pending;
    write_request_accept <= #1 !srst && pending < 256 && (!slow || $random(seed) % 3 != 0);
    payload_beat_ready <= #1 !srst && (!slow || $random(seed) % 2 == 0);
  end
endmodule : write_core_model
`default_nettype wire

/* write_traffic_generator.sv */
// write traffic generator: address, command and payload sections
`include "write_traffic_generator_defs.svh"
`default_nettype none
module write_traffic_generator
  import write_traffic_generator_pkg::*;
#(
  parameter int DEPTH = `WTG_QUEUE_DEPTH,
  parameter int DW    = `WTG_DATA_W
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  // user control
  input  wire logic                   start,
  input  wire logic [`WTG_ADDR_W-1:0] start_addr,
  input  wire logic [31:0]            transfer_len,
  input  wire logic                   address_order_select,
  input  wire logic [`WTG_ADDR_W-1:0] capacity,
  input  wire logic [`WTG_RATE_W-1:0] payload_rate_limit,
  output logic                        busy,
  // write request port
  output logic                        write_request_valid,
  output logic [`WTG_ADDR_W-1:0]      request_block_address,
  input  wire logic                   write_request_accept,
  // write payload port
  output logic                        payload_beat_valid,
  output logic [DW-1:0]               payload_data,
  input  wire logic                   payload_beat_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [`WTG_UNIT_LSB-1:0] LOW_ZERO = 3'h0;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [63:0] select_poly(input logic [`WTG_UNIT_W-1:0] cap);
    if (cap >= `WTG_CAP_8T) begin
      select_poly = {`WTG_MSB_0, `WTG_POLY_0};
    end else if (cap > `WTG_CAP_4T) begin
      select_poly = {`WTG_MSB_1, `WTG_POLY_1};
    end else if (cap > `WTG_CAP_2T) begin
      select_poly = {`WTG_MSB_2, `WTG_POLY_2};
    end else if (cap > `WTG_CAP_1T) begin
      select_poly = {`WTG_MSB_3, `WTG_POLY_3};
    end else if (cap > `WTG_CAP_512G) begin
      select_poly = {`WTG_MSB_4, `WTG_POLY_4};
    end else if (cap > `WTG_CAP_256G) begin
      select_poly = {`WTG_MSB_5, `WTG_POLY_5};
    end else begin
      select_poly = {`WTG_MSB_6, `WTG_POLY_6};
    end
  endfunction : select_poly

  function automatic logic [`WTG_LFSR_W-1:0] lfsr_step(input logic [`WTG_LFSR_W-1:0] cur,
                                                      input logic [63:0]             pm);
    logic [`WTG_LFSR_W-1:0] sh;
    sh = (cur >> 1) | pm[63:32];
    lfsr_step = cur[0] ? sh : (sh ^ pm[31:0]);
  endfunction : lfsr_step

  // ************************************************************
  // address queues: index 0 request, index 1 header
  // ************************************************************
  logic [1:0]                  q_push;
  logic [1:0]                  q_pop;
  logic [1:0]                  q_empty;
  logic [1:0]                  q_full;
  logic [`WTG_UNIT_W-1:0]      q_head [2];
  logic [`WTG_UNIT_W-1:0]      cur_addr;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_queue
      logic [`WTG_UNIT_W-1:0] mem [DEPTH];
      logic [PW:0]            wr_ptr;
      logic [PW:0]            rd_ptr;
      assign q_empty[g] = (wr_ptr == rd_ptr);
      assign q_full[g]  = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
      assign q_head[g]  = mem[rd_ptr[PW-1:0]];
      always_ff @(posedge core_clk) begin
        if (srst) begin
          wr_ptr <= '0;
          rd_ptr <= '0;
        end else begin
          if (q_push[g]) begin
            wr_ptr <= wr_ptr + 1'b1;
          end
          if (q_pop[g]) begin
            rd_ptr <= rd_ptr + 1'b1;
          end
        end
      end
      always_ff @(posedge core_clk) begin
        if (q_push[g]) begin
          mem[wr_ptr[PW-1:0]] <= cur_addr;
        end
      end
    end
  endgenerate

  // ************************************************************
  // address section
  // ************************************************************
  address_fsm_t            address_fsm_state;
  logic [31:0]             remaining;
  logic [`WTG_LFSR_W-1:0]  rand_addr;
  logic [63:0]             poly_sel;
  logic [`WTG_UNIT_W-1:0]  cap_last;
  logic                    random_mode;
  logic                    can_push;

  assign can_push  = !q_full[0] && !q_full[1];
  // same address into both queues in one cycle
  assign q_push[0] = (address_fsm_state == addr_write) && can_push;
  assign q_push[1] = q_push[0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      address_fsm_state <= addr_idle;
    end else begin
      case (address_fsm_state)
        addr_idle: begin
          if (start && (transfer_len != 32'h0)) begin
            address_fsm_state <= addr_write;
          end
        end
        addr_write: begin
          if (can_push) begin
            if (remaining == 32'h1) begin
              address_fsm_state <= addr_idle;
            end else if (random_mode) begin
              address_fsm_state <= addr_rand;
            end else begin
              address_fsm_state <= addr_inc;
            end
          end
        end
        addr_inc: begin
          address_fsm_state <= addr_write;
        end
        addr_rand: begin
          address_fsm_state <= addr_check;
        end
        addr_check: begin
          // out-of-range values are drawn again
          if ({13'h0, rand_addr} > cap_last) begin
            address_fsm_state <= addr_rand;
          end else begin
            address_fsm_state <= addr_write;
          end
        end
        default: begin
          address_fsm_state <= addr_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      remaining   <= 32'h0;
      random_mode <= 1'b0;
      poly_sel    <= 64'h0;
      cap_last    <= '0;
    end else if ((address_fsm_state == addr_idle) && start) begin
      // settings latched so a mid-run change cannot corrupt a sequence
      remaining   <= transfer_len;
      random_mode <= address_order_select;
      poly_sel    <= select_poly(capacity[`WTG_ADDR_W-1:`WTG_UNIT_LSB]);
      cap_last    <= capacity[`WTG_ADDR_W-1:`WTG_UNIT_LSB] - 1'b1;
    end else if (q_push[0]) begin
      remaining <= remaining - 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_addr  <= '0;
      rand_addr <= '0;
    end else begin
      case (address_fsm_state)
        addr_idle: begin
          if (start) begin
            cur_addr  <= start_addr[`WTG_ADDR_W-1:`WTG_UNIT_LSB];
            rand_addr <= start_addr[`WTG_UNIT_LSB+`WTG_LFSR_W-1:`WTG_UNIT_LSB];
          end
        end
        addr_inc: begin
          cur_addr <= cur_addr + 1'b1;
        end
        addr_rand: begin
          rand_addr <= lfsr_step(rand_addr, poly_sel);
        end
        addr_check: begin
          cur_addr <= {13'h0, rand_addr};
        end
        default: begin
          cur_addr <= cur_addr;
        end
      endcase
    end
  end

  // ************************************************************
  // command section
  // ************************************************************
  // output stage is a register, so pop whenever it is free or drains
  assign q_pop[0] = !q_empty[0] && (!write_request_valid || write_request_accept);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      write_request_valid   <= 1'b0;
      request_block_address <= '0;
    end else if (q_pop[0]) begin
      write_request_valid   <= 1'b1;
      request_block_address <= {q_head[0], LOW_ZERO};
    end else if (write_request_accept) begin
      write_request_valid <= 1'b0;
    end
  end

  // ************************************************************
  // rate window
  // ************************************************************
  logic [6:0] window_cnt;
  logic       rate_window_on;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      window_cnt     <= 7'h0;
      rate_window_on <= 1'b0;
    end else begin
      window_cnt     <= (window_cnt == 7'(`WTG_WINDOW - 1)) ? 7'h0 : window_cnt + 7'h1;
      rate_window_on <= (window_cnt < payload_rate_limit);
    end
  end

  // ************************************************************
  // data section
  // ************************************************************
  data_fsm_t              data_state;
  logic [6:0]             beat_cnt;
  logic [1:0]             pause_cnt;
  logic [`WTG_UNIT_W-1:0] header;
  logic                   gen_valid;
  logic [DW-1:0]          gen_data;
  logic                   buf_ready;

  assign q_pop[1]  = (data_state == data_idle) && !q_empty[1];
  assign gen_valid = (data_state == data_send) && rate_window_on && buf_ready;
  // beat 0 carries the header, later beats repeat the low 25 header bits with the beat count
  assign gen_data  = (beat_cnt == 7'h0) ? DW'({header, LOW_ZERO})
                   : {(DW/32){header[24:0], beat_cnt}};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_state <= data_idle;
      beat_cnt   <= 7'h0;
      pause_cnt  <= 2'h0;
      header     <= '0;
    end else begin
      case (data_state)
        data_idle: begin
          if (q_pop[1]) begin
            header     <= q_head[1];
            beat_cnt   <= 7'h0;
            data_state <= data_send;
          end
        end
        data_send: begin
          if (gen_valid) begin
            beat_cnt <= beat_cnt + 7'h1;
            if (beat_cnt == 7'(`WTG_BEATS - 1)) begin
              pause_cnt  <= 2'(`WTG_PAUSE - 1);
              data_state <= data_pause;
            end
          end
        end
        data_pause: begin
          if (pause_cnt == 2'h0) begin
            data_state <= data_idle;
          end else begin
            pause_cnt <= pause_cnt - 2'h1;
          end
        end
        default: begin
          data_state <= data_idle;
        end
      endcase
    end
  end

  // ************************************************************
  // two-entry payload buffer; slot 0 drives the port
  // ************************************************************
  logic          slot1_valid;
  logic [DW-1:0] slot1_data;
  logic          drain;

  assign buf_ready = !slot1_valid;
  assign drain     = payload_beat_valid && payload_beat_ready;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      payload_beat_valid <= 1'b0;
      slot1_valid        <= 1'b0;
      payload_data       <= '0;
      slot1_data         <= '0;
    end else if (drain || !payload_beat_valid) begin
      if (slot1_valid) begin
        payload_beat_valid <= 1'b1;
        payload_data       <= slot1_data;
        slot1_valid        <= gen_valid;
        slot1_data         <= gen_data;
      end else begin
        payload_beat_valid <= gen_valid;
        payload_data       <= gen_data;
      end
    end else if (gen_valid) begin
      slot1_valid <= 1'b1;
      slot1_data  <= gen_data;
    end
  end

  // ************************************************************
  // busy
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (address_fsm_state != addr_idle) || !q_empty[0] || !q_empty[1] || (data_state != data_idle)
              || write_request_valid || payload_beat_valid || slot1_valid;
    end
  end

endmodule : write_traffic_generator
`default_nettype wire

/* write_traffic_generator_bench.sv */
// self-checking bench for the write traffic generator
`include "write_traffic_generator_defs.svh"
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module write_traffic_generator_bench;
  import write_traffic_generator_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk, srst, start, address_order_select, slow, busy;
  logic                   write_request_valid, write_request_accept, payload_beat_valid, payload_beat_ready;
  logic [`WTG_ADDR_W-1:0] start_addr, capacity, request_block_address;
  logic [31:0]            transfer_len;
  logic [`WTG_RATE_W-1:0] payload_rate_limit;
  logic [`WTG_DATA_W-1:0] payload_data;
  logic [44:0]            exp_q[$];
  int                     fails, n_tests, ri, bi, bk, n_beats;
  int                     seed = 25733;
  // per-run capacity and the feedback pair its size class selects
  logic [47:0]            caps [6] = '{48'h0000_1800_0000, 48'h0000_1800_0000, 48'h0000_1800_0000,
                                       48'h0000_6000_0000, 48'h0004_0000_0000, 48'h0003_0000_0000};
  logic [31:0]            msbs [6] = '{`WTG_MSB_6, `WTG_MSB_6, `WTG_MSB_6, `WTG_MSB_4, `WTG_MSB_0, `WTG_MSB_1};
  logic [31:0]            polys [6] = '{`WTG_POLY_6, `WTG_POLY_6, `WTG_POLY_6, `WTG_POLY_4, `WTG_POLY_0,
                                        `WTG_POLY_1};
  write_traffic_generator DUT (.core_clk, .srst, .start, .start_addr, .transfer_len, .address_order_select,
    .capacity, .payload_rate_limit, .busy, .write_request_valid, .request_block_address, .write_request_accept,
    .payload_beat_valid, .payload_data, .payload_beat_ready);
  write_core_model core (.core_clk, .srst, .slow, .write_request_valid, .write_request_accept,
    .payload_beat_valid, .payload_beat_ready);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ****
  // expectations and monitors
  // ****
  function automatic logic [255:0] exp_beat(logic [44:0] a, int k);
    if (k == 0) return {208'h0, a, 3'h0};
    return {8{a[24:0], k[6:0]}};
  endfunction : exp_beat
  function automatic logic [31:0] next_rand(logic [31:0] r, logic [31:0] msb, logic [31:0] poly);
    logic l;
    l = r[0];
    r = (r >> 1) | msb;
    return l ? r : r ^ poly;
  endfunction : next_rand
  always @(posedge core_clk) begin
    if (!srst && write_request_valid === 1'b1 && write_request_accept === 1'b1) begin
      `CHK("request_block_address", {exp_q[ri], 3'h0}, request_block_address)
      ri++;
    end
    if (!srst && payload_beat_valid === 1'b1 && payload_beat_ready === 1'b1) begin
      `CHK("payload_data", exp_beat(exp_q[bi], bk), payload_data)
      n_beats++;
      bk = (bk == 127) ? 0 : bk + 1;
      if (bk == 0) bi++;
    end
  end
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wait_idle;
    repeat (3) tick();
    for (int i = 0; i < 30000 && busy !== 1'b0; i++) tick();
    `CHK("busy", 1'b0, busy)
    `CHK("requests", exp_q.size(), ri)
    `CHK("payloads", exp_q.size(), bi)
  endtask : wait_idle
  task automatic run(logic mode, logic [47:0] sa, int len, logic [47:0] cap, logic [31:0] msb, logic [31:0] poly);
    logic [31:0] r;
    logic [44:0] v;
    v = sa[47:3];
    r = sa[34:3];
    exp_q.push_back(v);
    for (int i = 1; i < len; i++) begin
      if (!mode) begin
        v = v + 45'h1;
      end else begin
        r = next_rand(r, msb, poly);
        while (r > cap[47:3] - 45'h1) r = next_rand(r, msb, poly);
        v = {13'h0, r};
      end
      exp_q.push_back(v);
    end
    address_order_select = mode;
    start_addr = sa;
    transfer_len = len;
    capacity = cap;
    start = 1'b1;
    tick();
    start = 1'b0;
  endtask : run
  task automatic finish_test;
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  // ****
  // main sequence
  // ****
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    {srst, start, slow, address_order_select} = 4'h8;
    {start_addr, capacity, transfer_len} = '0;
    payload_rate_limit = 7'd100;
    repeat (2) tick();
    srst = 1'b0;
    tick();
    start = 1'b1;
    tick();
    start = 1'b0;
    repeat (3) tick();
    `CHK("busy", 1'b0, busy)
    // a closed rate window must keep every beat back
    payload_rate_limit = 7'h00;
    run(1'b0, 48'h0000_0123_4567, 1, 48'h0004_0000_0000, 32'h0, 32'h0);
    repeat (250) tick();
    `CHK("beats_closed_window", 0, n_beats)
    payload_rate_limit = 7'd100;
    wait_idle();
    for (int k = 0; k < 6; k++) begin
      slow = k[0];
      payload_rate_limit = 7'd20 + 7'($unsigned($random(seed)) % 81);
      run(k >= 2, 48'($unsigned($random(seed)) & 32'h0FFF_FFFF), 2 + k, caps[k], msbs[k], polys[k]);
      wait_idle();
    end
    finish_test();
  end
endmodule : write_traffic_generator_bench
`default_nettype wire

/* write_traffic_generator_checker.sv */
// port checker for the write traffic generator
`include "write_traffic_generator_defs.svh"
`default_nettype none
module write_traffic_generator_checker
  import write_traffic_generator_pkg::*;
#(parameter int DW = `WTG_DATA_W) (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   srst,
  // user control
  input wire logic                   start,
  input wire logic [`WTG_ADDR_W-1:0] start_addr,
  input wire logic [31:0]            transfer_len,
  input wire logic                   address_order_select,
  input wire logic [`WTG_ADDR_W-1:0] capacity,
  input wire logic [`WTG_RATE_W-1:0] payload_rate_limit,
  input wire logic                   busy,
  // request port
  input wire logic                   write_request_valid,
  input wire logic [`WTG_ADDR_W-1:0] request_block_address,
  input wire logic                   write_request_accept,
  // payload port
  input wire logic                   payload_beat_valid,
  input wire logic [DW-1:0]          payload_data,
  input wire logic                   payload_beat_ready
);
  logic [6:0]             beat_idx;
  logic [`WTG_ADDR_W-1:0] last_addr;
  logic                   have_last;
  logic                   seq_run;
  // ****
  // helper state
  // ****
  always_ff @(posedge core_clk) begin
    if (srst) begin
      beat_idx <= 7'h00;
    end else if (payload_beat_valid && payload_beat_ready) begin
      beat_idx <= beat_idx + 7'h01;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      have_last <= 1'b0;
    end else if (start && !busy) begin
      have_last <= 1'b0;
      seq_run <= !address_order_select;
    end else if (write_request_valid && write_request_accept) begin
      have_last <= 1'b1;
      last_addr <= request_block_address;
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_req_taken;
    write_request_valid && write_request_accept;
  endsequence
  sequence s_beat_taken;
    payload_beat_valid && payload_beat_ready;
  endsequence
  a_addr_aligned: assert property (write_request_valid |-> request_block_address[2:0] == 3'h0)
    else $error("request address not aligned");
  a_req_holds: assert property (write_request_valid && !write_request_accept
    |=> write_request_valid && $stable(request_block_address)) else $error("request dropped");
  a_beat_holds: assert property (payload_beat_valid && !payload_beat_ready
    |=> payload_beat_valid && $stable(payload_data)) else $error("beat dropped");
  a_reset_quiet: assert property ($fell(srst) |-> !write_request_valid && !payload_beat_valid && !busy)
    else $error("outputs active after reset");
  a_busy_covers: assert property (write_request_valid || payload_beat_valid |-> busy)
    else $error("busy low with traffic");
  a_start_busy: assert property (start && !busy && transfer_len != 32'h0 |-> ##2 busy)
    else $error("start not taken");
  a_seq_step: assert property (s_req_taken ##0 (have_last && seq_run)
    |-> request_block_address == last_addr + 48'h8) else $error("sequential step wrong");
  a_header_form: assert property (s_beat_taken ##0 (beat_idx == 7'h00)
    |-> payload_data[DW-1:48] == '0 && payload_data[2:0] == 3'h0) else $error("header beat malformed");
  a_fill_index: assert property (s_beat_taken ##0 (beat_idx != 7'h00)
    |-> payload_data[6:0] == beat_idx) else $error("fill beat index wrong");
endmodule : write_traffic_generator_checker
bind write_traffic_generator write_traffic_generator_checker #(.DW(DW)) u_chk (.core_clk, .srst, .start,
  .start_addr, .transfer_len, .address_order_select, .capacity, .payload_rate_limit, .busy, .write_request_valid,
  .request_block_address, .write_request_accept, .payload_beat_valid, .payload_data, .payload_beat_ready);
`default_nettype wire

/* write_traffic_generator_defs.svh */
// constants for the write traffic generator
`ifndef WRITE_TRAFFIC_GENERATOR_DEFS_SVH
`define WRITE_TRAFFIC_GENERATOR_DEFS_SVH

`define WTG_ADDR_W      48
`define WTG_UNIT_W      45
`define WTG_UNIT_LSB    3
`define WTG_LFSR_W      32
`define WTG_DATA_W      256
`define WTG_QUEUE_DEPTH 16
`define WTG_BEATS       128
`define WTG_PAUSE       2
`define WTG_WINDOW      100
`define WTG_RATE_W      7

// capacity thresholds in 8 byte units
`define WTG_CAP_8T   45'h0000_8000_0000
`define WTG_CAP_4T   45'h0000_4000_0000
`define WTG_CAP_2T   45'h0000_2000_0000
`define WTG_CAP_1T   45'h0000_1000_0000
`define WTG_CAP_512G 45'h0000_0800_0000
`define WTG_CAP_256G 45'h0000_0400_0000

`define WTG_MSB_0  32'h8000_0000
`define WTG_POLY_0 32'hA300_0000
`define WTG_MSB_1  32'h4000_0000
`define WTG_POLY_1 32'h7800_0000
`define WTG_MSB_2  32'h2000_0000
`define WTG_POLY_2 32'h3280_0000
`define WTG_MSB_3  32'h1000_0000
`define WTG_POLY_3 32'h1D00_0000
`define WTG_MSB_4  32'h0800_0000
`define WTG_POLY_4 32'h0CA0_0000
`define WTG_MSB_5  32'h0400_0000
`define WTG_POLY_5 32'h0720_0000
`define WTG_MSB_6  32'h0200_0000
`define WTG_POLY_6 32'h0388_0000

`endif

/* write_traffic_generator_pkg.sv */
// types of the write traffic generator
`default_nettype none
package write_traffic_generator_pkg;
  typedef enum logic [2:0] {
    addr_idle  = 3'b000,
    addr_write = 3'b001,
    addr_inc   = 3'b010,
    addr_rand  = 3'b011,
    addr_check = 3'b100
  } address_fsm_t;

  typedef enum logic [1:0] {
    data_idle  = 2'b00,
    data_send  = 2'b01,
    data_pause = 2'b10
  } data_fsm_t;
endpackage : write_traffic_generator_pkg
`default_nettype wire
